//--- core/bsa_adapter.sv
// How it works
// - Sync detect pin resets as driven-low output.
// - Double sync: detect rises at last bit.
// - Status read clears sync detect flag.
// - Timers count at half system clock.
// - Counters 1,2 interrupt; readable port A.
// - Line marks until first character, CTS.
// - Bits shift out on transmit clock fall.
// - Transmit ready flag drives level-4 interrupt.
// - Idle transmitter inserts sync fill characters.
// - Empty flag holds during fill, data clears.
// - Enter hunt; sample on receive clock rise.
// - Hunt matches first then second sync.
// - Assembled byte sets receive ready, level-3.
// - Unread byte overwritten, overrun flag set.
// - Error reset command clears error flags.
// - Control word selects counter and load.
// - Lowest control bit picks binary or decimal.
// - Mode, then sync chars, then commands.
// - Internal reset bit returns to mode.
// - Control address read returns status word.
`include "bsa_params.svh"
module bsa_adapter (
  // Clock and synchronous reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Host I/O port access, one-cycle strobes.
  input wire logic [9:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Modem line pins.
  input wire logic tx_bit_clock_i,
  input wire logic rx_bit_clock_i,
  input wire logic rxd_i,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  output logic txd_o,
  output logic dtr_n_o,
  output logic rts_n_o,
  // Two-way sync detect pin.
  input wire logic sync_detect_i,
  output logic sync_detect_o,
  output logic sync_detect_oe_o,
  // Interrupt lines.
  output logic tx_ready_flag_o,
  output logic rx_ready_flag_o,
  output logic irq4_o,
  output logic irq3_o
);
  // ========================================================
  // Pin synchronisers.
  logic [5:0] pin_s1_q; // First stage, read only by the second.
  logic [5:0] pin_s2_q; // Usable pin levels.
  logic [1:0] clk_s3_q; // Delayed bit clocks for edge detection.
  wire [5:0] pins = {sync_detect_i, dsr_n_i, cts_n_i, rxd_i,
                     rx_bit_clock_i, tx_bit_clock_i};
  wire tx_fall = clk_s3_q[0] & ~pin_s2_q[0];
  wire rx_rise = ~clk_s3_q[1] & pin_s2_q[1];
  wire rxd_s = pin_s2_q[2];
  wire cts_on = ~pin_s2_q[3];
  // Two flops per pin keep metastability out of the logic.
  always_ff @(posedge sys_clk_i)
  begin
    pin_s1_q <= pins;
    pin_s2_q <= pin_s1_q;
    clk_s3_q <= pin_s2_q[1:0];
  end
  // ========================================================
  // Address decode.
  wire wr_data = io_wr_i & (io_addr_i == `BSA_A_DATA);
  wire wr_ctl = io_wr_i & (io_addr_i == `BSA_A_CTRL);
  wire rd_data = io_rd_i & (io_addr_i == `BSA_A_DATA);
  wire rd_stat = io_rd_i & (io_addr_i == `BSA_A_CTRL);
  wire wr_pb = io_wr_i & (io_addr_i == `BSA_A_PORTB);
  wire wr_tcw = io_wr_i & (io_addr_i == `BSA_A_TCW);
  wire [1:0] hit_cnt = {io_addr_i == `BSA_A_CNT2,
                        io_addr_i == `BSA_A_CNT1};
  // ========================================================
  // Port B latch; bit 4 holds the serial core in reset.
  logic [7:0] portb_q;
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      portb_q <= `BSA_RST_BYTE;
    else if (wr_pb)
      portb_q <= io_wdata_i;
  end
  wire mres = ~resetn_i | portb_q[`BSA_PB_RESET];
  // ========================================================
  // Control write sequencing: mode, sync chars, commands.
  bsa_pkg::bsa_ctl_state_t state_q;
  logic [7:0] mode_q, sync1_q, sync2_q, cmd_q;
  wire in_cmd = (state_q == bsa_pkg::BSA_CMD);
  wire irst = wr_ctl & in_cmd & io_wdata_i[`BSA_CMD_IRST];
  wire err_rst = wr_ctl & in_cmd & io_wdata_i[`BSA_CMD_ERST];
  wire hunt_cmd = wr_ctl & in_cmd & io_wdata_i[`BSA_CMD_HUNT];
  wire ures = mres | irst;
  wire single = mode_q[`BSA_MODE_SINGLE];
  // Each control write lands according to the sequence state.
  always_ff @(posedge sys_clk_i)
  begin
    if (mres)
    begin
      state_q <= bsa_pkg::BSA_WAIT_MODE;
      mode_q <= `BSA_RST_BYTE;
      sync1_q <= `BSA_RST_BYTE;
      sync2_q <= `BSA_RST_BYTE;
      cmd_q <= `BSA_RST_BYTE;
    end
    else if (wr_ctl)
      case (state_q)
        bsa_pkg::BSA_WAIT_MODE:
        begin
          mode_q <= io_wdata_i;
          state_q <= bsa_pkg::BSA_WAIT_SYN1;
        end
        bsa_pkg::BSA_WAIT_SYN1:
        begin
          sync1_q <= io_wdata_i;
          state_q <= single ? bsa_pkg::BSA_CMD : bsa_pkg::BSA_WAIT_SYN2;
        end
        bsa_pkg::BSA_WAIT_SYN2:
        begin
          sync2_q <= io_wdata_i;
          state_q <= bsa_pkg::BSA_CMD;
        end
        bsa_pkg::BSA_CMD:
        begin
          // Internal reset drops back to expecting a mode byte.
          state_q <= irst ? bsa_pkg::BSA_WAIT_MODE : state_q;
          cmd_q <= irst ? `BSA_RST_BYTE : io_wdata_i;
        end
        default: state_q <= bsa_pkg::BSA_WAIT_MODE;
      endcase
  end
  assign dtr_n_o = ~cmd_q[`BSA_CMD_DTR];
  assign rts_n_o = ~cmd_q[`BSA_CMD_RTS];
  // ========================================================
  // Transmitter with sync fill.
  logic [7:0] tx_hold_q, tx_sh_q;
  logic [2:0] tx_cnt_q;
  logic tx_full_q, tx_run_q, tx_empty_q, txd_q, fill_alt_q;
  wire tx_go = cmd_q[`BSA_CMD_TXEN] & cts_on;
  wire bound = tx_fall & (tx_cnt_q == 3'h0);
  wire tx_take = bound & tx_full_q & (tx_run_q | tx_go);
  wire tx_fill = bound & ~tx_full_q & tx_run_q & tx_go;
  wire [7:0] fill_ch = (fill_alt_q & ~single) ? sync2_q : sync1_q;
  // Holding register; a write wins over the shifter taking it.
  always_ff @(posedge sys_clk_i)
  begin
    if (ures)
      tx_full_q <= 1'b0;
    else if (wr_data)
      tx_full_q <= 1'b1;
    else if (tx_take)
      tx_full_q <= 1'b0;
    if (wr_data)
      tx_hold_q <= io_wdata_i;
  end
  // Shifter; one bit per falling transmit clock, LSB first.
  always_ff @(posedge sys_clk_i)
  begin
    if (ures)
    begin
      tx_run_q <= 1'b0;
      txd_q <= 1'b1; // Mark level until the first character.
      tx_cnt_q <= 3'h0;
      tx_sh_q <= `BSA_RST_BYTE;
      fill_alt_q <= 1'b0;
    end
    else if (tx_take | tx_fill)
    begin
      tx_run_q <= 1'b1;
      txd_q <= tx_take ? tx_hold_q[0] : fill_ch[0];
      tx_sh_q <= {1'b0, (tx_take ? tx_hold_q[7:1] : fill_ch[7:1])};
      tx_cnt_q <= 3'h7;
      fill_alt_q <= tx_fill & ~fill_alt_q;
    end
    else if (bound)
    begin
      // Nothing left and transmitter off: return to mark.
      tx_run_q <= 1'b0;
      txd_q <= 1'b1;
    end
    else if (tx_fall)
    begin
      txd_q <= tx_sh_q[0];
      tx_sh_q <= {1'b0, tx_sh_q[7:1]};
      tx_cnt_q <= tx_cnt_q - 3'h1;
    end
  end
  // Empty flag: raised by fill, lowered only by a data write.
  always_ff @(posedge sys_clk_i)
  begin
    if (ures)
      tx_empty_q <= 1'b1;
    else if (tx_fill)
      tx_empty_q <= 1'b1;
    else if (wr_data)
      tx_empty_q <= 1'b0;
  end
  assign txd_o = txd_q;
  assign tx_ready_flag_o = ~tx_full_q & tx_go;
  // ========================================================
  // Receiver: hunt, bisync alignment, assembly.
  logic [7:0] rx_sh_q, rx_buf_q;
  logic [2:0] rx_cnt_q;
  logic hunt_q, second_q, rx_rdy_q, overrun_q, sync_detect_q;
  wire [7:0] rx_next = {rxd_s, rx_sh_q[7:1]};
  wire m1 = (rx_next == sync1_q);
  wire last = (rx_cnt_q == 3'h7);
  wire sync_hit = rx_rise & hunt_q & (second_q ?
                  (last & (rx_next == sync2_q)) : (m1 & single));
  wire rx_done = rx_rise & ~hunt_q & last;
  wire rx_en = cmd_q[`BSA_CMD_RXEN];
  // Bit-level hunt then byte framing on rising receive clock.
  always_ff @(posedge sys_clk_i)
  begin
    if (ures | hunt_cmd)
    begin
      hunt_q <= 1'b1;
      second_q <= 1'b0;
      rx_cnt_q <= 3'h0;
    end
    else if (rx_rise)
    begin
      rx_cnt_q <= rx_cnt_q + 3'h1;
      if (sync_hit)
      begin
        hunt_q <= 1'b0;
        second_q <= 1'b0;
        rx_cnt_q <= 3'h0;
      end
      else if (hunt_q & ~second_q)
      begin
        second_q <= m1;
        rx_cnt_q <= 3'h0;
      end
      else if (hunt_q & last)
        second_q <= 1'b0; // Second char missed: hunt again.
    end
    if (mres)
      rx_sh_q <= `BSA_RST_BYTE;
    else if (rx_rise)
      rx_sh_q <= rx_next;
    if (rx_done)
      rx_buf_q <= rx_next;
  end
  // Receive flags; hardware set wins over host clear.
  always_ff @(posedge sys_clk_i)
  begin
    if (ures | ~rx_en)
      rx_rdy_q <= 1'b0;
    else if (rx_done)
      rx_rdy_q <= 1'b1;
    else if (rd_data)
      rx_rdy_q <= 1'b0;
    if (ures)
      overrun_q <= 1'b0;
    else if (rx_done & rx_rdy_q & ~rd_data)
      overrun_q <= 1'b1;
    else if (err_rst)
      overrun_q <= 1'b0;
    if (ures)
      sync_detect_q <= 1'b0;
    else if (sync_hit)
      sync_detect_q <= 1'b1;
    else if (rd_stat)
      sync_detect_q <= 1'b0;
  end
  assign rx_ready_flag_o = rx_rdy_q;
  assign irq3_o = rx_rdy_q;
  // Pin is an input only in external sync mode.
  assign sync_detect_oe_o = ~mode_q[`BSA_MODE_EXT];
  assign sync_detect_o = sync_detect_q & sync_detect_oe_o;
  // ========================================================
  // Inactivity timers, counters 1 and 2 in mode 0.
  logic tick_q; // Half-rate count tick.
  logic [15:0] cnt_q [2];
  logic [15:0] lat_q [2];
  logic [7:0] lsb_q [2];
  logic [1:0] rl_q [2];
  logic [1:0] bcd_q, run_q, out_q, wptr_q, rptr_q, latd_q;
  wire [1:0] sc = io_wdata_i[`BSA_TCW_SC];
  wire [1:0] rlw = io_wdata_i[`BSA_TCW_RL];
  // Decrement by one in binary or four-decade decimal.
  function automatic logic [15:0] bsa_dec(input logic [15:0] v,
                                          input logic bcd);
    logic [15:0] r;
    logic br;
    r = v - 16'h0001;
    br = 1'b1;
    if (bcd)
      for (int k = 0; k < 4; k++)
      begin
        r[4*k +: 4] = !br ? v[4*k +: 4] :
                      (v[4*k +: 4] == 4'h0) ? 4'h9 : v[4*k +: 4] - 4'h1;
        br = br & (v[4*k +: 4] == 4'h0);
      end
    return r;
  endfunction
  // Divide the system clock by two.
  always_ff @(posedge sys_clk_i)
  begin
    tick_q <= !resetn_i ? 1'b0 : ~tick_q;
  end
  // Control word, loads, latches and counting per counter.
  always_ff @(posedge sys_clk_i)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!resetn_i)
      begin
        cnt_q[i] <= `BSA_RST_CNT;
        lat_q[i] <= `BSA_RST_CNT;
        lsb_q[i] <= `BSA_RST_BYTE;
        rl_q[i] <= bsa_pkg::BSA_RL_BOTH;
        {bcd_q[i], run_q[i], out_q[i]} <= 3'b000;
        {wptr_q[i], rptr_q[i], latd_q[i]} <= 3'b000;
      end
      else if (wr_tcw & (sc == 2'(i + 1)) & (rlw == 2'b00))
      begin
        lat_q[i] <= cnt_q[i];
        latd_q[i] <= 1'b1;
      end
      else if (wr_tcw & (sc == 2'(i + 1)))
      begin
        rl_q[i] <= rlw;
        bcd_q[i] <= io_wdata_i[`BSA_TCW_BCD];
        {run_q[i], out_q[i], wptr_q[i], rptr_q[i]} <= 4'h0;
      end
      else if (io_wr_i & hit_cnt[i])
      begin
        case (rl_q[i])
          bsa_pkg::BSA_RL_LSB: cnt_q[i] <= {8'h00, io_wdata_i};
          bsa_pkg::BSA_RL_MSB: cnt_q[i] <= {io_wdata_i, 8'h00};
          default: cnt_q[i] <= {io_wdata_i, lsb_q[i]};
        endcase
        lsb_q[i] <= io_wdata_i;
        wptr_q[i] <= (rl_q[i] == 2'b11) & ~wptr_q[i];
        run_q[i] <= (rl_q[i] != 2'b11) | wptr_q[i];
        out_q[i] <= 1'b0;
      end
      else
      begin
        if (run_q[i] & tick_q)
        begin
          cnt_q[i] <= bsa_dec(cnt_q[i], bcd_q[i]);
          out_q[i] <= out_q[i] | (cnt_q[i] == 16'h0001);
        end
        if (io_rd_i & hit_cnt[i])
        begin
          rptr_q[i] <= (rl_q[i] == 2'b11) & ~rptr_q[i];
          latd_q[i] <= latd_q[i] & (rl_q[i] == 2'b11) & ~rptr_q[i];
        end
      end
    end
  end
  assign irq4_o = tx_ready_flag_o | out_q[0] | out_q[1];
  // ========================================================
  // Read data path.
  wire cs = hit_cnt[1];
  wire [15:0] cval = latd_q[cs] ? lat_q[cs] : cnt_q[cs];
  wire hi_b = (rl_q[cs] == 2'b10) | ((rl_q[cs] == 2'b11) & rptr_q[cs]);
  wire syn_bit = mode_q[`BSA_MODE_EXT] ? pin_s2_q[5] : sync_detect_q;
  wire [7:0] stat = {~pin_s2_q[4], syn_bit, 1'b0, overrun_q, 1'b0,
                     tx_empty_q, rx_rdy_q, ~tx_full_q};
  wire [7:0] rd_val =
    rd_stat ? stat :
    rd_data ? rx_buf_q :
    (io_addr_i == `BSA_A_PORTA) ? {out_q[0], out_q[1], 6'h00} :
    (io_addr_i == `BSA_A_PORTB) ? portb_q :
    (|hit_cnt) ? (hi_b ? cval[15:8] : cval[7:0]) : 8'h00;
  // Read data registers one cycle after the strobe.
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      io_rdata_o <= `BSA_RST_BYTE;
    else if (io_rd_i)
      io_rdata_o <= rd_val;
  end
  // ========================================================
  // Assertions.
  property p_syn_reset;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    !$past(resetn_i) |-> sync_detect_oe_o && !sync_detect_o;
  endproperty
  a_syn_reset: assert property (p_syn_reset)
    else $error("sync detect pin not low output after reset");
  property p_syn_clear;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    rd_stat && !sync_hit |=> !sync_detect_q;
  endproperty
  a_syn_clear: assert property (p_syn_clear)
    else $error("status read did not clear sync detect");
  property p_hit;
    @(posedge sys_clk_i) disable iff (mres)
    sync_hit && !hunt_cmd && !irst |=> sync_detect_q && !hunt_q;
  endproperty
  a_hit: assert property (p_hit)
    else $error("sync match did not end hunt");
  property p_tick;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    tick_q |=> !tick_q ##1 tick_q;
  endproperty
  a_tick: assert property (p_tick)
    else $error("timer tick not at half rate");
  property p_txd_edge;
    @(posedge sys_clk_i) disable iff (mres)
    $changed(txd_o) |-> $past(tx_fall) || $past(ures);
  endproperty
  a_txd_edge: assert property (p_txd_edge)
    else $error("serial output changed off a clock fall");
  property p_mark;
    @(posedge sys_clk_i) disable iff (mres)
    !tx_run_q |-> txd_o;
  endproperty
  a_mark: assert property (p_mark)
    else $error("serial output not marking while idle");
  property p_empty;
    @(posedge sys_clk_i) disable iff (mres)
    tx_empty_q && !wr_data && !irst |=> tx_empty_q;
  endproperty
  a_empty: assert property (p_empty)
    else $error("empty flag dropped without a data write");
  property p_ovr;
    @(posedge sys_clk_i) disable iff (mres)
    rx_done && rx_rdy_q && rx_en && !rd_data && !irst
      |=> overrun_q && rx_rdy_q;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun not flagged");
  property p_err;
    @(posedge sys_clk_i) disable iff (mres)
    err_rst && !rx_done |=> !overrun_q;
  endproperty
  a_err: assert property (p_err)
    else $error("error reset left overrun set");
  property p_irst;
    @(posedge sys_clk_i) disable iff (mres)
    irst |=> state_q == bsa_pkg::BSA_WAIT_MODE && cmd_q == 8'h00;
  endproperty
  a_irst: assert property (p_irst)
    else $error("internal reset did not return to mode");
  property p_porta;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    io_rd_i && io_addr_i == `BSA_A_PORTA
      |=> io_rdata_o[7:6] == {$past(out_q[0]), $past(out_q[1])};
  endproperty
  a_porta: assert property (p_porta)
    else $error("timer outputs not on port A");
  property p_rx_ready_flag;
    @(posedge sys_clk_i) disable iff (mres)
    rx_done && rx_en && !irst |=> irq3_o && rx_ready_flag_o;
  endproperty
  a_rx_ready_flag: assert property (p_rx_ready_flag)
    else $error("receive ready not raised");
endmodule

//--- core/bsa_params.svh
`ifndef BSA_PARAMS_SVH
`define BSA_PARAMS_SVH
// ==========================================================
// Host I/O port addresses.
`define BSA_A_PORTA 10'h3a0
`define BSA_A_PORTB 10'h3a1
`define BSA_A_CNT1 10'h3a5
`define BSA_A_CNT2 10'h3a6
`define BSA_A_TCW 10'h3a7
`define BSA_A_DATA 10'h3a8
`define BSA_A_CTRL 10'h3a9
// ==========================================================
// Command instruction bit positions.
`define BSA_CMD_HUNT 0
`define BSA_CMD_IRST 1
`define BSA_CMD_RTS 2
`define BSA_CMD_ERST 3
`define BSA_CMD_RXEN 5
`define BSA_CMD_DTR 6
`define BSA_CMD_TXEN 7
// ==========================================================
// Mode instruction bit positions.
`define BSA_MODE_EXT 6
`define BSA_MODE_SINGLE 7
// ==========================================================
// Peripheral port bits and timer control word fields.
`define BSA_PB_RESET 4
`define BSA_TCW_SC 7:6
`define BSA_TCW_RL 5:4
`define BSA_TCW_BCD 0
// ==========================================================
// Reset values.
`define BSA_RST_BYTE 8'h00
`define BSA_RST_CNT 16'h0000
`endif

//--- core/bsa_pkg.sv
// ==========================================================
// Shared types of the serial adapter.
package bsa_pkg;
  // Control write sequencing, one-hot.
  typedef enum logic [3:0] {
    BSA_WAIT_MODE = 4'b0001,
    BSA_WAIT_SYN1 = 4'b0010,
    BSA_WAIT_SYN2 = 4'b0100,
    BSA_CMD = 4'b1000
  } bsa_ctl_state_t;
  // Timer read/load field codes.
  typedef enum logic [1:0] {
    BSA_RL_LATCH = 2'b00,
    BSA_RL_LSB = 2'b01,
    BSA_RL_MSB = 2'b10,
    BSA_RL_BOTH = 2'b11
  } bsa_rl_t;
endpackage

//--- verif/bsa_modem.sv
// ==========================================================
// Synchronous modem model: bit clocks, receive feed, capture.
module bsa_modem (
  // Clocks and receive data toward the adapter.
  output logic tx_bit_clock_o,
  output logic rx_bit_clock_o,
  output logic rxd_o,
  // Transmit data from the adapter.
  input wire logic txd_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Receive bits still to send, oldest first.
  logic q[$];
  // Transmit bits seen, newest in the top bit.
  logic [63:0] tx_hist;
  // Transmit changes seen while the bit clock was high.
  int late_edges;
  // The clocks run free; their periods differ so phases drift.
  initial
  begin
    tx_bit_clock_o = 1'b0;
    rx_bit_clock_o = 1'b0;
    rxd_o = 1'b1;
    tx_hist = '0;
    late_edges = 0;
  end
  always #800 tx_bit_clock_o = ~tx_bit_clock_o;
  always #810 rx_bit_clock_o = ~rx_bit_clock_o;
  // Queues one character, bit 0 first on the line.
  task automatic push_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      q.push_back(b[i]);
  endtask
  // Bits change on the fall so the rising edge sees mid-bit.
  always @(negedge rx_bit_clock_o)
  begin
    // An empty queue leaves the line at mark.
    if (q.size() != 0)
      rxd_o <= q.pop_front();
    else
      rxd_o <= 1'b1;
  end
  // Transmit bits are taken on the rising edge.
  always @(posedge tx_bit_clock_o)
    tx_hist <= {txd_i, tx_hist[63:1]};
  // A change in the high phase means a shift off the falling edge.
  always @(txd_i)
    if (tx_bit_clock_o)
      late_edges++;
endmodule

//--- verif/bisync_serial_adapter_tb.sv
`include "bsa_params.svh"
// ==========================================================
// Self-checking bench for the serial adapter.
module bisync_serial_adapter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Design connections.
  logic sys_clk_i, resetn_i, io_wr_i, io_rd_i;
  logic [9:0] io_addr_i;
  logic [7:0] io_wdata_i, io_rdata_o, rd_val;
  logic tx_bit_clock_i, rx_bit_clock_i, rxd_i, cts_n_i, dsr_n_i;
  logic txd_o, dtr_n_o, rts_n_o, tx_ready_flag_o, rx_ready_flag_o;
  logic sync_detect_i, sync_detect_o, sync_detect_oe_o, irq4_o, irq3_o;
  // Verdict counters.
  int mismatches = 0;
  int checks_done = 0;
  // The sync pin has a pull-down when nobody drives it.
  assign sync_detect_i = sync_detect_oe_o ? sync_detect_o : 1'b0;
  bsa_adapter uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .tx_bit_clock_i(tx_bit_clock_i), .rx_bit_clock_i(rx_bit_clock_i),
    .rxd_i(rxd_i), .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i), .txd_o(txd_o),
    .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o), .sync_detect_i(sync_detect_i),
    .sync_detect_o(sync_detect_o), .sync_detect_oe_o(sync_detect_oe_o),
    .tx_ready_flag_o(tx_ready_flag_o), .rx_ready_flag_o(rx_ready_flag_o),
    .irq4_o(irq4_o), .irq3_o(irq3_o));
  bsa_modem modem (.tx_bit_clock_o(tx_bit_clock_i),
    .rx_bit_clock_o(rx_bit_clock_i), .rxd_o(rxd_i), .txd_i(txd_o));
  // ==========================================================
  // Shared tasks.
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Compares one value and reports a difference at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One host write, strobe high for a single cycle.
  task automatic io_write(input logic [9:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge sys_clk_i);
    io_wr_i = 1'b0;
  endtask
  // One host read; the data is taken once it has settled.
  task automatic io_read(input logic [9:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge sys_clk_i);
    io_rd_i = 1'b0;
    @(negedge sys_clk_i);
    d = io_rdata_o;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // Waits until the modem has at most n receive bits left.
  task automatic wait_bits(input int n);
    for (int k = 0; k < 3000 && modem.q.size() > n; k++)
      @(negedge sys_clk_i);
  endtask
  // ==========================================================
  // Scenarios.
  // Control writes go mode, sync, command; internal reset restarts.
  task automatic test_sequence();
    for (int r = 0; r < 2; r++)
    begin
      io_write(`BSA_A_CTRL, 8'hc0);
      io_write(`BSA_A_CTRL, 8'h40);
      cycles(2);
      check(dtr_n_o, 1'b1);
      check(sync_detect_oe_o, 1'b0);
      io_write(`BSA_A_CTRL, 8'h40);
      cycles(2);
      check(dtr_n_o, 1'b0);
      io_write(`BSA_A_CTRL, 8'h02);
      cycles(2);
      check(dtr_n_o, 1'b1);
    end
  endtask
  // Hunt, sync detect, data, overrun and error reset.
  task automatic test_receive();
    logic [7:0] seq [6];
    seq = '{8'hff, 8'h32, 8'h16, 8'ha5, 8'h3c, 8'hc3};
    foreach (seq[i])
      modem.push_byte(seq[i]);
    wait_bits(24);
    check(sync_detect_o, 1'b0);
    cycles(14);
    check(sync_detect_o, 1'b1);
    io_read(`BSA_A_CTRL, rd_val);
    check(rd_val & 8'hc0, 8'hc0);
    check(sync_detect_o, 1'b0);
    io_read(`BSA_A_CTRL, rd_val);
    check(rd_val[6], 1'b0);
    wait_bits(16);
    cycles(14);
    check({rx_ready_flag_o, irq3_o}, 2'b11);
    io_read(`BSA_A_DATA, rd_val);
    check(rd_val, 8'ha5);
    check(rx_ready_flag_o, 1'b0);
    wait_bits(0);
    cycles(14);
    io_read(`BSA_A_CTRL, rd_val);
    check(rd_val[4], 1'b1);
    io_read(`BSA_A_DATA, rd_val);
    check(rd_val, 8'hc3);
    io_write(`BSA_A_CTRL, 8'h6c);
    io_read(`BSA_A_CTRL, rd_val);
    check(rd_val[4], 1'b0);
    // With the receiver off the ready flag stays low.
    io_write(`BSA_A_CTRL, 8'h44);
    cycles(200);
    check(rx_ready_flag_o, 1'b0);
  endtask
  // First sync character waits for clear-to-send, then fill.
  task automatic test_transmit();
    logic found;
    found = 1'b0;
    io_write(`BSA_A_CTRL, 8'hc4);
    io_read(`BSA_A_CTRL, rd_val);
    check(rd_val[2:0], 3'b101);
    check(tx_ready_flag_o, 1'b0);
    io_write(`BSA_A_DATA, 8'h32);
    cycles(40);
    check(txd_o, 1'b1);
    io_read(`BSA_A_CTRL, rd_val);
    check(rd_val[2], 1'b0);
    cts_n_i = 1'b0;
    for (int n = 0; n < 400 && tx_ready_flag_o !== 1'b1; n++)
      @(negedge sys_clk_i);
    check(irq4_o, 1'b1);
    io_write(`BSA_A_DATA, 8'h5a);
    io_read(`BSA_A_CTRL, rd_val);
    check(rd_val[2], 1'b0);
    cycles(300);
    io_read(`BSA_A_CTRL, rd_val);
    check(rd_val[2], 1'b1);
    cycles(128);
    io_read(`BSA_A_CTRL, rd_val);
    check(rd_val[2], 1'b1);
    cycles(200);
    for (int i = 0; i <= 32; i++)
      if (modem.tx_hist[i +: 32] === 32'h16325a32)
        found = 1'b1;
    check(found, 1'b1);
    check(modem.late_edges[7:0], 8'h00);
  endtask
  // Counters run at half rate; binary and decimal counts differ.
  task automatic test_timers();
    io_write(`BSA_A_CTRL, 8'h04);
    cts_n_i = 1'b1;
    cycles(2);
    check(irq4_o, 1'b0);
    io_write(`BSA_A_TCW, 8'h70);
    io_write(`BSA_A_CNT1, 8'h05);
    io_write(`BSA_A_CNT1, 8'h00);
    cycles(6);
    check(irq4_o, 1'b0);
    cycles(8);
    check(irq4_o, 1'b1);
    io_read(`BSA_A_PORTA, rd_val);
    check(rd_val, 8'h80);
    io_write(`BSA_A_TCW, 8'h70);
    io_write(`BSA_A_TCW, 8'hb1);
    io_write(`BSA_A_CNT2, 8'h10);
    io_write(`BSA_A_CNT2, 8'h00);
    cycles(15);
    check(irq4_o, 1'b0);
    cycles(10);
    check(irq4_o, 1'b1);
    io_write(`BSA_A_TCW, 8'hf1);
    io_read(`BSA_A_PORTA, rd_val);
    check(rd_val, 8'h40);
    io_read(10'h3a4, rd_val);
    check(rd_val, 8'h00);
    // A latched count must stay put while the live count moves on.
    io_write(`BSA_A_TCW, 8'h70);
    io_write(`BSA_A_CNT1, 8'h34);
    io_write(`BSA_A_CNT1, 8'h12);
    io_write(`BSA_A_TCW, 8'h40);
    cycles(600);
    io_read(`BSA_A_CNT1, rd_val);
    io_read(`BSA_A_CNT1, rd_val);
    check(rd_val, 8'h12);
  endtask
  // ==========================================================
  // Clock, watchdog and main sequence.
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // The run needs a few thousand cycles; this cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    final_report();
  end
  initial
  begin
    resetn_i = 1'b0;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    io_addr_i = 10'h000;
    io_wdata_i = 8'h00;
    cts_n_i = 1'b1;
    dsr_n_i = 1'b0;
    cycles(2);
    check({txd_o, dtr_n_o, rts_n_o, sync_detect_oe_o, sync_detect_o,
      irq4_o, irq3_o, rx_ready_flag_o}, 8'hf0);
    resetn_i = 1'b1;
    cycles(1);
    check({sync_detect_oe_o, sync_detect_o}, 2'b10);
    io_write(10'h3a3, 8'h98);
    io_write(10'h3a2, 8'h0d);
    io_write(`BSA_A_PORTB, 8'h10);
    cycles(6);
    io_write(`BSA_A_PORTB, 8'h00);
    test_sequence();
    io_write(`BSA_A_CTRL, 8'h00);
    io_write(`BSA_A_CTRL, 8'h32);
    io_write(`BSA_A_CTRL, 8'h16);
    io_write(`BSA_A_CTRL, 8'h65);
    cycles(2);
    check({dtr_n_o, rts_n_o}, 2'b00);
    test_receive();
    test_transmit();
    test_timers();
    final_report();
  end
endmodule
